// ### hdl/smsh_spi.sv
//
// What this block does
// RULE1: Outgoing word is loaded into the shift register before any transfer starts.
// RULE2: Completed received word is placed in the receive buffer for software.
// RULE3: Master or slave selectable; master alone starts transfers and drives serial clock.
// RULE4: All four polarity and phase combinations selectable; both ends must match.
// RULE5: Pin set selectable: three pins, four with select or handshake, five.
// RULE6: Slave with select enabled shifts and drives output only while select low.
// RULE7: Slave handshake output optional, driven push-pull or open-drain.
// RULE8: Slave handshake reflects the internal transmit buffer state.
// RULE9: Four-pin handshake mode: asserted only while transmit buffer full.
// RULE10: Five-pin mode: asserted only while buffer full and slave selected.
// RULE11: Master with handshake waits for slave ready before next transfer.
// RULE12: Deselected slave leaves its output data pin undriven.
`timescale 1ns/100ps
module smsh_spi
#(
   parameter int DATA_W   = smsh_pkg::DATA_W_DEF,
   parameter int FIFO_D   = smsh_pkg::FIFO_D_DEF,
   parameter int HALF_CYC = smsh_pkg::SCK_HALF_CYC
)
(
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic              MASTER,
   input  wire logic              CPOL,
   input  wire logic              CPHA,
   input  wire logic [1:0]        PIN_MODE,
   input  wire logic              RDY_OPEN_DRAIN,
   input  wire logic [DATA_W-1:0] TX_DATA,
   input  wire logic              TX_VALID,
   output logic                   TX_READY,
   output logic [DATA_W-1:0]      RX_DATA,
   output logic                   RX_VALID,
   output logic                   BUSY,
   input  wire logic              SERIAL_CLOCK_PIN_I,
   output logic                   SERIAL_CLOCK_PIN_O,
   output logic                   SERIAL_CLOCK_PIN_OE_N,
   input  wire logic              MASTER_OUT_DATA_PIN_I,
   output logic                   MASTER_OUT_DATA_PIN_O,
   output logic                   MASTER_OUT_DATA_PIN_OE_N,
   input  wire logic              SLAVE_OUT_DATA_PIN_I,
   output logic                   SLAVE_OUT_DATA_PIN_O,
   output logic                   SLAVE_OUT_DATA_PIN_OE_N,
   input  wire logic              SLAVE_SELECT_PIN_I,
   output logic                   SLAVE_SELECT_PIN_O,
   output logic                   SLAVE_SELECT_PIN_OE_N,
   input  wire logic              READY_HANDSHAKE_PIN_I,
   output logic                   READY_HANDSHAKE_PIN_O,
   output logic                   READY_HANDSHAKE_PIN_OE_N
);
   localparam int                EW       = $clog2(2 * DATA_W + 1);
   localparam int                DW       = $clog2(HALF_CYC + 1);
   localparam logic [EW-1:0]     EDGE_END = EW'(2 * DATA_W);
   localparam logic [DW-1:0]     DIV_TOP  = DW'(HALF_CYC - 1);

   logic [smsh_pkg::SYNC_N-1:0] pin_raw;
   logic [smsh_pkg::SYNC_N-1:0] pin_f;
   smsh_pkg::smsh_state_t       state_reg;
   logic [DATA_W-1:0]           tx_word_reg;
   logic                        tx_full_reg;
   logic [DATA_W-1:0]           shift_reg;
   logic [DATA_W-1:0]           rx_shift_reg;
   logic [DATA_W-1:0]           rx_buf_reg;
   logic                        rx_valid_reg;
   logic [EW-1:0]               edge_cnt_reg;
   logic [DW-1:0]               div_cnt_reg;
   logic                        sclk_reg;
   logic                        sclk_prev_reg;
   logic                        rdy_level_reg;
   logic                        busy_reg;
   logic                        mosi_o_reg, mosi_oe_n_reg;
   logic                        miso_o_reg, miso_oe_n_reg;
   logic                        sclk_oe_n_reg;
   logic                        sel_o_reg, sel_oe_n_reg;
   logic                        rdy_o_reg, rdy_oe_n_reg;
   logic [DATA_W-1:0]           fifo_data;
   logic                        fifo_valid;
   logic                        fifo_take;
   logic                        sel_used, rdy_used, selected, rdy_ok;
   logic                        m_edge, s_edge, edge_ev, lead_ev;
   logic                        sample_ev, shift_ev, last_sample, start_ev;
   logic                        edge_sample, edge_last, tx_buf_full;
   logic [1:0]                  samp_dly_reg, last_dly_reg;

   assign pin_raw = {READY_HANDSHAKE_PIN_I, SLAVE_SELECT_PIN_I, SLAVE_OUT_DATA_PIN_I,
                     MASTER_OUT_DATA_PIN_I, SERIAL_CLOCK_PIN_I};

   // Three-stage synchroniser; a change is taken once the last two agree
   for (genvar i = 0; i < smsh_pkg::SYNC_N; i++)
   begin : g_sync
      logic [2:0] s_reg;
      logic       f_reg;
      always_ff @(posedge CLK or negedge RST_N)
      begin
         if (!RST_N)
         begin
            s_reg <= {3{smsh_pkg::SYNC_RST[i]}};
            f_reg <= smsh_pkg::SYNC_RST[i];
         end
         else
         begin
            s_reg <= {s_reg[1:0], pin_raw[i]};
            if (s_reg[1] == s_reg[2])
               f_reg <= s_reg[2];
         end
      end
      assign pin_f[i] = f_reg;
   end

   smsh_fifo #(.W(DATA_W), .DEPTH(FIFO_D)) u_fifo
   (
      .CLK       (CLK),
      .RST_N     (RST_N),
      .in_data   (TX_DATA),
      .in_valid  (TX_VALID),
      .in_ready  (TX_READY),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );

   assign sel_used = (PIN_MODE == smsh_pkg::PINS_4_SEL) || (PIN_MODE == smsh_pkg::PINS_5);
   assign rdy_used = (PIN_MODE == smsh_pkg::PINS_4_RDY) || (PIN_MODE == smsh_pkg::PINS_5);
   assign selected = !sel_used || !pin_f[smsh_pkg::SYNC_SEL];
   assign rdy_ok   = !rdy_used || pin_f[smsh_pkg::SYNC_RDY];

   // Staging word empties into the shift register, so the queue refills it
   assign fifo_take = !tx_full_reg || start_ev;
   assign start_ev  = (state_reg == smsh_pkg::ST_IDLE) && tx_full_reg
                      && (!MASTER || rdy_ok);                           // see RULE1 RULE11

   assign m_edge  = MASTER && (state_reg == smsh_pkg::ST_SHIFT) && (div_cnt_reg == DIV_TOP);
   assign s_edge  = !MASTER && (state_reg == smsh_pkg::ST_SHIFT) && selected
                    && (pin_f[smsh_pkg::SYNC_SCLK] != sclk_prev_reg);   // see RULE6
   assign edge_ev = m_edge || s_edge;
   assign lead_ev = MASTER ? (sclk_reg == CPOL) : (pin_f[smsh_pkg::SYNC_SCLK] != CPOL);
   assign edge_sample = edge_ev && (lead_ev != CPHA);                   // see RULE4
   assign shift_ev    = edge_ev && (lead_ev == CPHA) && (edge_cnt_reg != '0);
   assign edge_last   = edge_sample
                        && (edge_cnt_reg == (CPHA ? EDGE_END - 1'b1 : EDGE_END - 2'd2));
   // Master reads late: its data input lags its own clock by the synchroniser
   assign sample_ev   = MASTER ? samp_dly_reg[1] : edge_sample;
   assign last_sample = MASTER ? last_dly_reg[1] : edge_last;
   // Slave word loaded but not yet clocked still counts as buffered
   assign tx_buf_full = tx_full_reg
                        || (!MASTER && (state_reg == smsh_pkg::ST_SHIFT) && (edge_cnt_reg == '0));

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         tx_word_reg <= '0;
         tx_full_reg <= 1'b0;
      end
      else if (fifo_take)
      begin
         tx_full_reg <= fifo_valid;
         if (fifo_valid)
            tx_word_reg <= fifo_data;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_reg    <= smsh_pkg::ST_IDLE;
         edge_cnt_reg <= '0;
         shift_reg    <= '0;
      end
      else
      begin
         case (state_reg)
            smsh_pkg::ST_IDLE:
            begin
               edge_cnt_reg <= '0;
               if (start_ev)
               begin
                  shift_reg <= tx_word_reg;                             // see RULE1
                  state_reg <= smsh_pkg::ST_SHIFT;
               end
            end
            smsh_pkg::ST_SHIFT:
            begin
               if (edge_ev)
                  edge_cnt_reg <= edge_cnt_reg + 1'b1;
               if (shift_ev)
                  shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
               if (edge_ev && (edge_cnt_reg == EDGE_END - 1'b1))
                  state_reg <= smsh_pkg::ST_IDLE;
            end
            default:
               state_reg <= smsh_pkg::ST_IDLE;
         endcase
      end
   end

   // Receive buffer takes the word on the final sampling edge
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rx_buf_reg   <= '0;
         rx_valid_reg <= 1'b0;
         rx_shift_reg <= '0;
         samp_dly_reg <= 2'h0;
         last_dly_reg <= 2'h0;
      end
      else
      begin
         samp_dly_reg <= {samp_dly_reg[0], edge_sample};
         last_dly_reg <= {last_dly_reg[0], edge_last};
         if (sample_ev)
            rx_shift_reg <= {rx_shift_reg[DATA_W-2:0],
               MASTER ? pin_f[smsh_pkg::SYNC_MISO] : pin_f[smsh_pkg::SYNC_MOSI]};
         rx_valid_reg <= last_sample;                                   // see RULE2
         if (last_sample)
            rx_buf_reg <= {rx_shift_reg[DATA_W-2:0],
               MASTER ? pin_f[smsh_pkg::SYNC_MISO] : pin_f[smsh_pkg::SYNC_MOSI]};
      end
   end

   // Serial clock generator; parks at the idle polarity between words
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         div_cnt_reg   <= '0;
         sclk_reg      <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end
      else
      begin
         sclk_prev_reg <= pin_f[smsh_pkg::SYNC_SCLK];
         if (!MASTER || state_reg == smsh_pkg::ST_IDLE)
         begin
            div_cnt_reg <= '0;
            sclk_reg    <= CPOL;                                        // see RULE4
         end
         else if (m_edge)
         begin
            div_cnt_reg <= '0;
            sclk_reg    <= !sclk_reg;                                   // see RULE3
         end
         else
            div_cnt_reg <= div_cnt_reg + 1'b1;
      end
   end

   // Handshake level: buffer full, and in five-pin mode also selected
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         rdy_level_reg <= 1'b0;
      else
         rdy_level_reg <= tx_buf_full
            && ((PIN_MODE != smsh_pkg::PINS_5) || selected);            // see RULE8 RULE9 RULE10
   end

   // Pin drivers; enables are low while driving
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sclk_oe_n_reg <= 1'b1;
         mosi_o_reg    <= 1'b0;
         mosi_oe_n_reg <= 1'b1;
         miso_o_reg    <= 1'b0;
         miso_oe_n_reg <= 1'b1;
         sel_o_reg     <= 1'b1;
         sel_oe_n_reg  <= 1'b1;
         rdy_o_reg     <= 1'b0;
         rdy_oe_n_reg  <= 1'b1;
         busy_reg      <= 1'b0;
      end
      else
      begin
         busy_reg      <= (state_reg == smsh_pkg::ST_SHIFT);
         sclk_oe_n_reg <= !MASTER;                                      // see RULE3
         mosi_o_reg    <= shift_reg[DATA_W-1];
         mosi_oe_n_reg <= !MASTER;
         miso_o_reg    <= shift_reg[DATA_W-1];
         miso_oe_n_reg <= MASTER || !selected;                          // see RULE6 RULE12
         sel_o_reg     <= (state_reg != smsh_pkg::ST_SHIFT);
         sel_oe_n_reg  <= !(MASTER && sel_used);                        // see RULE5
         // Open drain only pulls low for not ready, so idle slaves can share it
         if (MASTER || !rdy_used)
         begin
            rdy_o_reg    <= 1'b0;
            rdy_oe_n_reg <= 1'b1;                                       // see RULE5 RULE11
         end
         else if (RDY_OPEN_DRAIN)
         begin
            rdy_o_reg    <= 1'b0;
            rdy_oe_n_reg <= rdy_level_reg;                              // see RULE7
         end
         else
         begin
            rdy_o_reg    <= rdy_level_reg;
            rdy_oe_n_reg <= 1'b0;                                       // see RULE7
         end
      end
   end

   assign RX_DATA                  = rx_buf_reg;
   assign RX_VALID                 = rx_valid_reg;
   assign BUSY                     = busy_reg;
   assign SERIAL_CLOCK_PIN_O       = sclk_reg;
   assign SERIAL_CLOCK_PIN_OE_N    = sclk_oe_n_reg;
   assign MASTER_OUT_DATA_PIN_O    = mosi_o_reg;
   assign MASTER_OUT_DATA_PIN_OE_N = mosi_oe_n_reg;
   assign SLAVE_OUT_DATA_PIN_O     = miso_o_reg;
   assign SLAVE_OUT_DATA_PIN_OE_N  = miso_oe_n_reg;
   assign SLAVE_SELECT_PIN_O       = sel_o_reg;
   assign SLAVE_SELECT_PIN_OE_N    = sel_oe_n_reg;
   assign READY_HANDSHAKE_PIN_O    = rdy_o_reg;
   assign READY_HANDSHAKE_PIN_OE_N = rdy_oe_n_reg;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_load_first;
      (state_reg == smsh_pkg::ST_IDLE) ##1 (state_reg == smsh_pkg::ST_SHIFT)
         |-> $past(tx_full_reg) && (shift_reg == $past(tx_word_reg));
   endproperty
   a_load_first: assert property (p_load_first) else $error("shift started unloaded"); // see RULE1

   property p_rx_buf;
      last_sample |=> rx_valid_reg && (rx_buf_reg[DATA_W-1:1] == $past(rx_shift_reg[DATA_W-2:0]));
   endproperty
   a_rx_buf: assert property (p_rx_buf) else $error("receive buffer not updated"); // see RULE2

   property p_clock_owner;
      $stable(MASTER) |=> (SERIAL_CLOCK_PIN_OE_N == !$past(MASTER));
   endproperty
   a_clock_owner: assert property (p_clock_owner) else $error("clock drive wrong"); // see RULE3

   property p_idle_polarity;
      (MASTER && state_reg == smsh_pkg::ST_IDLE && $stable(CPOL)) [*2] |-> sclk_reg == CPOL;
   endproperty
   a_idle_polarity: assert property (p_idle_polarity) else $error("idle clock level"); // see RULE4

   property p_select_pin;
      $stable(PIN_MODE) && !(MASTER && sel_used) |=> SLAVE_SELECT_PIN_OE_N;
   endproperty
   a_select_pin: assert property (p_select_pin) else $error("select driven"); // see RULE5

   property p_deselect_hiz;
      !MASTER && sel_used && pin_f[smsh_pkg::SYNC_SEL] |=> SLAVE_OUT_DATA_PIN_OE_N && !s_edge;
   endproperty
   a_deselect_hiz: assert property (p_deselect_hiz) else $error("deselected slave active"); // see RULE6 RULE12

   property p_open_drain;
      !MASTER && rdy_used && RDY_OPEN_DRAIN |=> !READY_HANDSHAKE_PIN_O;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drives high"); // see RULE7

   property p_rdy_four;
      PIN_MODE == smsh_pkg::PINS_4_RDY |=> rdy_level_reg == $past(tx_buf_full);
   endproperty
   a_rdy_four: assert property (p_rdy_four) else $error("handshake not buffer state"); // see RULE8 RULE9

   property p_rdy_five;
      PIN_MODE == smsh_pkg::PINS_5 && !selected |=> !rdy_level_reg;
   endproperty
   a_rdy_five: assert property (p_rdy_five) else $error("unselected slave ready"); // see RULE10

   property p_master_waits;
      MASTER && rdy_used && !pin_f[smsh_pkg::SYNC_RDY] && state_reg == smsh_pkg::ST_IDLE
         |=> state_reg == smsh_pkg::ST_IDLE;
   endproperty
   a_master_waits: assert property (p_master_waits) else $error("master ignored handshake"); // see RULE11

   c_master_word: cover property (MASTER && last_sample);
   c_slave_word: cover property (!MASTER && last_sample);
   c_master_wait: cover property (MASTER && rdy_used && tx_full_reg && !rdy_ok);
   c_cpha_one: cover property (CPHA && CPOL && rx_valid_reg);

endmodule

// ### hdl/smsh_pkg.sv
package smsh_pkg;

   // Pin configurations
   localparam logic [1:0] PINS_3      = 2'h0;
   localparam logic [1:0] PINS_4_SEL  = 2'h1;
   localparam logic [1:0] PINS_4_RDY  = 2'h2;
   localparam logic [1:0] PINS_5      = 2'h3;

   // Synchroniser indices and filtered values after reset
   localparam int         SYNC_SCLK   = 0;
   localparam int         SYNC_MOSI   = 1;
   localparam int         SYNC_MISO   = 2;
   localparam int         SYNC_SEL    = 3;
   localparam int         SYNC_RDY    = 4;
   localparam int         SYNC_N      = 5;
   localparam logic [4:0] SYNC_RST    = 5'h08;

   // Serial clock timing for master mode
   localparam int         CLK_PERIOD_NS = 50;
   localparam int         SCK_HALF_NS   = 200;
   localparam int         SCK_HALF_CYC  =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int         DATA_W_DEF  = 16;
   localparam int         FIFO_D_DEF  = 16;

   typedef enum logic {ST_IDLE, ST_SHIFT} smsh_state_t;

endpackage

// ### hdl/smsh_fifo.sv
`timescale 1ns/100ps
module smsh_fifo
#(
   parameter int W     = 16,
   parameter int DEPTH = 16
)
(
   input  wire logic         CLK,
   input  wire logic         RST_N,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic          in_ready_reg;
   logic          push;
   logic          pop;

   assign push      = in_valid && in_ready_reg;
   assign pop       = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign in_ready  = in_ready_reg;

   always_comb
   begin
      count_next = count_reg;
      if (push && !pop)
         count_next = count_reg + 1'b1;
      else if (pop && !push)
         count_next = count_reg - 1'b1;
   end

   // Ready is registered so the top level sees it straight from a flop
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         count_reg    <= '0;
         in_ready_reg <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         count_reg    <= count_next;
         in_ready_reg <= (count_next != CW'(DEPTH));
      end
   end

   always_ff @(posedge CLK)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end

endmodule

// ### tb/smsh_far_slave.sv
`timescale 1ns/100ps
module smsh_far_slave
#(
   parameter int W = 16
)
(
   input  wire logic         clk,
   input  wire logic         en,
   input  wire logic         sclk,
   input  wire logic         mosi,
   input  wire logic         cpha,
   input  wire logic [W-1:0] tx_word,
   input  wire logic         rdy_en,
   input  wire logic [7:0]   lag,
   output logic              miso,
   output logic              rdy,
   output logic [W-1:0]      rx_word,
   output logic              rx_done
);
   int         n       = 0;
   int         idx;
   logic       mid     = 1'b0;
   logic [7:0] lag_reg = 8'h00;

   // Bit index follows the shared phase setting
   assign idx  = cpha ? ((n == 0) ? 0 : (n - 1) / 2) : n / 2;
   assign miso = tx_word[W-1-idx];
   // Ready drops as a word starts, returns lag cycles after it ends
   assign rdy  = rdy_en && !mid && (lag_reg == 8'h00);

   initial rx_done = 1'b0;

   always @(sclk)
   begin
      if (en)
      begin
         mid = 1'b1;
         if (n[0] == cpha)
            rx_word = {rx_word[W-2:0], mosi};
         n = n + 1;
         if (n == 2 * W)
         begin
            n       = 0;
            mid     = 1'b0;
            rx_done = 1'b1;
         end
      end
   end

   // Disabled while config changes: idle level steps are no edges
   always @(posedge clk)
   begin
      if (!en)
      begin
         n   = 0;
         mid = 1'b0;
      end
      if (rx_done)
      begin
         rx_done <= 1'b0;
         lag_reg <= lag;
      end
      else if (lag_reg != 8'h00)
         lag_reg <= lag_reg - 8'h01;
   end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, master = 1'b0, cpol = 1'b0, cpha = 1'b0;
   logic        od = 1'b0, tx_valid = 1'b0, tb_sclk = 1'b0, tb_mosi = 1'b0;
   logic        tb_sel = 1'b1, far_en = 1'b0, far_rdy_en = 1'b0, float_v = 1'b0;
   logic [1:0]  pin_mode = 2'h0;
   logic [7:0]  lag = 8'h00;
   logic [15:0] tx_data = 16'h0000, far_word = 16'h0000, rx_data, far_rx;
   logic [31:0] seed = 32'h3de0_d6b4;
   logic        tx_ready, rx_valid, busy, far_miso, far_rdy, far_done;
   logic        sc_o, sc_oe_n, mo_o, mo_oe_n, so_o, so_oe_n, ss_o, ss_oe_n, rd_o, rd_oe_n;
   logic [15:0] exp_rx[$], exp_far[$];
   int          fails = 0, checks = 0, cyc = 0;

   // Undriven data line shows a changing pattern; ready has a pull-up
   wire sclk_w = !sc_oe_n ? sc_o : tb_sclk;
   wire mosi_w = !mo_oe_n ? mo_o : tb_mosi;
   wire miso_w = !so_oe_n ? so_o : (master ? far_miso : float_v);
   wire sel_w  = !ss_oe_n ? ss_o : tb_sel;
   wire rdy_w  = !rd_oe_n ? rd_o : (master ? far_rdy : 1'b1);

   smsh_spi dut (.CLK(clk), .RST_N(rst_n), .MASTER(master), .CPOL(cpol), .CPHA(cpha),
      .PIN_MODE(pin_mode), .RDY_OPEN_DRAIN(od), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid), .BUSY(busy),
      .SERIAL_CLOCK_PIN_I(sclk_w), .SERIAL_CLOCK_PIN_O(sc_o),
      .SERIAL_CLOCK_PIN_OE_N(sc_oe_n), .MASTER_OUT_DATA_PIN_I(mosi_w),
      .MASTER_OUT_DATA_PIN_O(mo_o), .MASTER_OUT_DATA_PIN_OE_N(mo_oe_n),
      .SLAVE_OUT_DATA_PIN_I(miso_w), .SLAVE_OUT_DATA_PIN_O(so_o),
      .SLAVE_OUT_DATA_PIN_OE_N(so_oe_n), .SLAVE_SELECT_PIN_I(sel_w),
      .SLAVE_SELECT_PIN_O(ss_o), .SLAVE_SELECT_PIN_OE_N(ss_oe_n),
      .READY_HANDSHAKE_PIN_I(rdy_w), .READY_HANDSHAKE_PIN_O(rd_o),
      .READY_HANDSHAKE_PIN_OE_N(rd_oe_n));

   smsh_far_slave far (.clk(clk), .en(far_en), .sclk(sclk_w), .mosi(mosi_w), .cpha(cpha),
      .tx_word(far_word), .rdy_en(far_rdy_en), .lag(lag), .miso(far_miso), .rdy(far_rdy),
      .rx_word(far_rx), .rx_done(far_done));

   always #25 clk = ~clk;

   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic take(ref logic [15:0] q[$], input logic [15:0] got);
      if (q.size() == 0)
      begin
         fails++;
         $display("[ERR] %0t unexpected word %h", $time, got);
      end
      else
         cmp(got, q.pop_front());
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One offer; caller keeps valid up between words
   task automatic push(input logic [15:0] w, output bit ok);
      logic r;
      tx_data  <= w;
      tx_valid <= 1'b1;
      @(negedge clk);
      r = tx_ready;
      @(posedge clk);
      ok = (r === 1'b1);
   endtask

   task automatic put(input logic [15:0] w);
      bit ok;
      do push(w, ok); while (!ok);
      tx_valid <= 1'b0;
   endtask

   task automatic drain();
      int t;
      for (t = 0; t < 6000 && (exp_rx.size() > 0 || exp_far.size() > 0); t++)
         @(posedge clk);
      cmp(exp_rx.size() + exp_far.size(), 16'h0000);
      wait_clk(4);
   endtask

   // Bench as master, idle low, sample on rising; read late for settled data
   task automatic xfer(input logic [15:0] mw, output logic [15:0] got);
      for (int i = 15; i >= 0; i--)
      begin
         tb_mosi <= mw[i];
         wait_clk(4);
         tb_sclk <= 1'b1;
         wait_clk(4);
         got[i] = miso_w;
         tb_sclk <= 1'b0;
      end
      wait_clk(8);
   endtask

   always @(posedge clk)
   begin
      float_v <= ~float_v;
      if (rst_n === 1'b1 && rx_valid === 1'b1)
         take(exp_rx, rx_data);
   end

   always @(posedge far_done)
      take(exp_far, far_rx);

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         tally_and_finish();
      end
   end

   initial
   begin
      logic [15:0] w, fw, got;
      bit          ok;
      int          n;
      repeat (8) @(posedge clk);
      rst_n  <= 1'b1;
      master <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         far_en   <= 1'b0;
         {cpol, cpha} <= k[1:0];
         pin_mode <= k[0] ? smsh_pkg::PINS_4_SEL : smsh_pkg::PINS_3;
         wait_clk(4);
         far_en <= 1'b1;
         fw = rnd();
         far_word <= fw;
         exp_rx.push_back(fw);
         w = rnd();
         exp_far.push_back(w);
         put(w);
         wait_clk(20);
         cmp(sel_w, !k[0]);
         cmp(sc_oe_n, 1'b0);
         drain();
      end
      $display("test master phase and polarity done");
      far_en <= 1'b0;
      {cpol, cpha} <= 2'h0;
      pin_mode <= smsh_pkg::PINS_4_RDY;
      wait_clk(8);
      far_en <= 1'b1;
      fw = rnd();
      far_word <= fw;
      n  = 0;
      ok = 1'b1;
      // Slave never ready: buffer fills until refused
      while (ok && n < 40)
      begin
         w = rnd();
         push(w, ok);
         if (ok)
         begin
            n++;
            exp_far.push_back(w);
            exp_rx.push_back(fw);
         end
      end
      tx_valid <= 1'b0;
      @(negedge clk);
      cmp(n >= 16, 1'b1);
      cmp(busy, 1'b0);
      cmp(exp_far.size() == n, 1'b1);
      lag        <= 8'h14;
      far_rdy_en <= 1'b1;
      drain();
      cmp(tx_ready, 1'b1);
      $display("test master handshake and buffer done");
      master   <= 1'b0;
      far_en   <= 1'b0;
      pin_mode <= smsh_pkg::PINS_5;
      wait_clk(8);
      w = rnd();
      put(w);
      repeat (3)
      begin
         tb_sclk <= 1'b1;
         wait_clk(4);
         tb_sclk <= 1'b0;
         wait_clk(4);
      end
      cmp(so_oe_n, 1'b1);
      cmp(rdy_w, 1'b0);
      cmp(sc_oe_n, 1'b1);
      tb_sel <= 1'b0;
      wait_clk(8);
      cmp(so_oe_n, 1'b0);
      cmp(rdy_w, 1'b1);
      fw = rnd();
      exp_rx.push_back(fw);
      xfer(fw, got);
      cmp(got, w);
      cmp(rdy_w, 1'b0);
      tb_sel <= 1'b1;
      drain();
      $display("test slave five pin done");
      pin_mode <= smsh_pkg::PINS_4_RDY;
      od       <= 1'b1;
      wait_clk(8);
      cmp(rd_oe_n, 1'b0);
      cmp(rdy_w, 1'b0);
      w = rnd();
      put(w);
      wait_clk(8);
      cmp(rd_oe_n, 1'b1);
      cmp(rdy_w, 1'b1);
      fw = rnd();
      exp_rx.push_back(fw);
      xfer(fw, got);
      cmp(got, w);
      cmp(rd_oe_n, 1'b0);
      drain();
      $display("test slave open drain handshake done");
      tally_and_finish();
   end
endmodule
